// ==== rtl/wport_fifo.sv ====
/*
 * word fifo with valid/ready on both sides, width and depth parameters.
 * assumes the caller lives on the same clock and a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module wport_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_in_valid,
    output logic                          o_in_ready,
    input  wire logic [WIDTH-1:0]         i_in_data,
    output logic                          o_out_valid,
    input  wire logic                     i_out_ready,
    output logic [WIDTH-1:0]              o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]    o_count
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    wire              push;
    wire              pop;

    assign o_in_ready  = (count_ff != CW'(DEPTH));
    assign o_out_valid = (count_ff != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr_ff];
    assign o_count     = count_ff;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff  <= CW'(count_ff + CW'(push) - CW'(pop));
        end
    end
endmodule : wport_fifo
`default_nettype wire

// ==== rtl/wport_pkg.sv ====
/*
 * shared constants and carriers for the write port / test reset block.
 * assumes a single 50 MHz system clock and an AHB-Lite register bus.
 */
package wport_pkg;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam int unsigned TAP_RST_TICKS = 5;
    localparam logic [2:0]  TICK_LAST     = 3'h4;

    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] DATA_OFS   = 12'h008;

    localparam int unsigned CTRL_ASYNC_BIT = 0;
    localparam int unsigned CTRL_LEVEL_BIT = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    localparam int unsigned ST_TAP_OK_BIT  = 0;
    localparam int unsigned ST_EMPTY_BIT   = 1;
    localparam int unsigned ST_FULL_BIT    = 2;
    localparam int unsigned ST_ASYNC_BIT   = 3;
    localparam int unsigned ST_LEVEL_BIT   = 4;
    localparam int unsigned ST_COUNT_LSB   = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } word_s;

    typedef enum logic [1:0] {
        TAP_UNRESET = 2'b00,
        TAP_READY   = 2'b01
    } tap_state_e;
endpackage : wport_pkg

// ==== rtl/wport_top.sv ====
/*
 * fifo write port control with test access reset gating the o_q_out enable.
 * assumes pins arrive asynchronous to i_sys_clk; an AHB-Lite master drives
 * the register bus; a downstream reader drains o_rd_data.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - test reset pin resets controller at the next i_sys_clk edge
// - no power-up reset; pin or five mode-highs
// - o_q_out high-impedance (o_q_oe_n high) until controller reset
// - sync mode writes only with enable low
// - enabled write-clock rising edge stores word
// - async mode: strobe rising edge stores word
// - HSTL level: deselect blocks data inputs
module wport_top
    import wport_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_wr_clk,
    input  wire logic              i_write_en_n,
    input  wire logic              i_write_port_select_n,
    input  wire logic              i_write_level_select,
    input  wire logic              i_async_write,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_master_reset_n,
    input  wire logic              i_test_reset_n,
    input  wire logic              i_test_clk,
    input  wire logic              i_test_mode_sel,
    input  wire logic              i_rd_ready,
    output logic                   o_rd_valid,
    output logic [DATA_W-1:0]      o_rd_data,
    output logic [DATA_W-1:0]      o_q_out,
    output logic                   o_q_oe_n,
    output logic                   o_wr_overflow,
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic [31:0]            o_hrdata,
    output logic                   o_hreadyout,
    output logic                   o_hresp
);
    // two-stage synchronisers for the eight control pins; write data is delayed three stages
    localparam int unsigned NSYNC = 8;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    wire  [NSYNC-1:0] pins;
    assign pins = {i_wr_clk, i_write_en_n, i_write_port_select_n, i_write_level_select,
                   i_async_write, i_master_reset_n, i_test_clk, i_test_mode_sel};

    logic [DATA_W-1:0] d1_ff;
    logic [DATA_W-1:0] d2_ff;
    logic [DATA_W-1:0] d3_ff;

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    s1_ff[g] <= 1'b0;
                    s2_ff[g] <= 1'b0;
                    s3_ff[g] <= 1'b0;
                end else begin
                    s1_ff[g] <= pins[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        d1_ff <= i_wr_data;
        d2_ff <= d1_ff;
        d3_ff <= d2_ff;
    end

    wire wclk_s   = s2_ff[7];
    wire wclk_d   = s3_ff[7];
    wire wen_n_s  = s2_ff[6];
    wire wsel_n_s = s2_ff[5];
    wire lvl_s    = s2_ff[4];
    wire async_s  = s2_ff[3];
    wire mrst_n_s = s2_ff[2];
    wire tck_s    = s2_ff[1];
    wire tck_d    = s3_ff[1];
    wire tms_s    = s2_ff[0];
    wire wclk_rise = wclk_s && !wclk_d;
    wire tck_rise  = tck_s && !tck_d;

    // static configuration latched while master reset is low
    logic async_cfg_ff;
    logic level_cfg_ff;
    logic [1:0] ctrl_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            async_cfg_ff <= 1'b0;
            level_cfg_ff <= 1'b0;
        end else if (!mrst_n_s) begin
            async_cfg_ff <= async_s ^ ctrl_ff[CTRL_ASYNC_BIT];
            level_cfg_ff <= lvl_s ^ ctrl_ff[CTRL_LEVEL_BIT];
        end
    end

    // write qualification
    wire inputs_on  = !(level_cfg_ff && wsel_n_s);
    wire sync_wr    = !async_cfg_ff && !wen_n_s && wclk_rise;
    wire async_wr   = async_cfg_ff && wclk_rise;
    wire pin_wr     = (sync_wr || async_wr) && inputs_on && mrst_n_s;

    // bus decode
    wire        bus_take  = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
    logic       ph_wr_ff;
    logic       ph_rd_ff;
    logic [11:0] ph_addr_ff;
    wire        bus_wr_data = ph_wr_ff && (ph_addr_ff == DATA_OFS);
    wire        bus_wr_ctrl = ph_wr_ff && (ph_addr_ff == CTRL_OFS);

    // fifo input: pin writes take priority over bus pushes
    wire              in_valid = pin_wr || bus_wr_data;
    wire [DATA_W-1:0] in_data  = pin_wr ? d3_ff : i_hwdata;
    wire              in_ready;
    wire              f_valid;
    wire [DATA_W-1:0] f_data;
    wire [3:0]        f_count;
    wire              pop = f_valid && (!o_rd_valid || i_rd_ready);

    wport_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst || !mrst_n_s),
        .i_in_valid  (in_valid),
        .o_in_ready  (in_ready),
        .i_in_data   (in_data),
        .o_out_valid (f_valid),
        .i_out_ready (pop),
        .o_out_data  (f_data),
        .o_count     (f_count)
    );

    // test access controller reset
    tap_state_e tap_ff;
    logic [2:0] tms_cnt_ff;
    logic       trst_m_ff;
    logic       trst_s_ff;

    always_ff @(posedge i_sys_clk or negedge i_test_reset_n) begin
        if (!i_test_reset_n) begin
            trst_m_ff <= 1'b1;
            trst_s_ff <= 1'b1;
        end else begin
            trst_m_ff <= 1'b0;
            trst_s_ff <= trst_m_ff;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (trst_s_ff) begin
            tap_ff     <= TAP_READY;
            tms_cnt_ff <= '0;
        end else if (i_rst) begin
            tap_ff     <= TAP_UNRESET;
            tms_cnt_ff <= '0;
        end else if (tck_rise) begin
            tms_cnt_ff <= tms_s ? ((tms_cnt_ff == TICK_LAST) ? tms_cnt_ff
                                   : 3'(tms_cnt_ff + 3'h1)) : 3'h0;
            if (tms_s && tms_cnt_ff == TICK_LAST) begin
                tap_ff <= TAP_READY;
            end
        end
    end

    // outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_valid    <= 1'b0;
            o_rd_data     <= '0;
            o_q_out       <= '0;
            o_q_oe_n      <= 1'b1;
            o_wr_overflow <= 1'b0;
        end else begin
            if (pop) begin
                o_rd_valid <= 1'b1;
                o_rd_data  <= f_data;
                o_q_out    <= f_data;
            end else if (i_rd_ready) begin
                o_rd_valid <= 1'b0;
            end
            o_q_oe_n      <= (tap_ff != TAP_READY);
            o_wr_overflow <= in_valid && !in_ready;
        end
    end

    // AHB-Lite slave
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ph_wr_ff   <= 1'b0;
            ph_rd_ff   <= 1'b0;
            ph_addr_ff <= '0;
            ctrl_ff    <= CTRL_RESET;
            o_hrdata   <= '0;
        end else begin
            ph_wr_ff   <= bus_take && i_hwrite;
            ph_rd_ff   <= bus_take && !i_hwrite;
            ph_addr_ff <= bus_take ? i_haddr[11:0] : ph_addr_ff;
            if (bus_wr_ctrl) begin
                ctrl_ff <= i_hwdata[1:0];
            end
            if (bus_take && !i_hwrite) begin
                unique case (i_haddr[11:0])
                    CTRL_OFS:   o_hrdata <= {30'h0, ctrl_ff};
                    STATUS_OFS: o_hrdata <= {20'h0, f_count, 3'h0,
                                             level_cfg_ff, async_cfg_ff, !in_ready,
                                             !f_valid, (tap_ff == TAP_READY)};
                    default:    o_hrdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end
endmodule : wport_top
`default_nettype wire

// ==== sim/wport_top_assertions.sv ====
/* port checker for wport_top: test reset gating and write acceptance.
   bound to every wport_top; config pins static after master reset. */
`timescale 1ns/1ps
`default_nettype none
module wport_top_assertions
    import wport_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wr_clk,
    input wire logic i_write_en_n,
    input wire logic i_write_port_select_n,
    input wire logic i_write_level_select,
    input wire logic i_async_write,
    input wire logic i_master_reset_n,
    input wire logic i_test_reset_n,
    input wire logic i_test_clk,
    input wire logic i_test_mode_sel,
    input wire logic i_rd_ready,
    input wire logic i_hsel,
    input wire logic o_rd_valid,
    input wire logic o_q_oe_n,
    input wire logic o_wr_overflow
);
    logic       tclk_ff;
    logic       wclk_ff;
    logic       seen_ff;
    logic [2:0] edge_ff;
    logic [3:0] quiet_ff;
    wire        push_ok = !i_write_en_n && !(i_write_level_select && i_write_port_select_n);
    wire        wrise   = i_wr_clk && !wclk_ff;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_sys_clk) begin
        tclk_ff <= i_test_clk;
        wclk_ff <= i_wr_clk;
        if (i_rst || !i_test_mode_sel) edge_ff <= 3'h0;
        else if (i_test_clk && !tclk_ff && edge_ff != 3'h5) edge_ff <= edge_ff + 3'h1;
        if (i_rst && i_test_reset_n) seen_ff <= 1'b0;
        else if (!i_test_reset_n || edge_ff == 3'h5) seen_ff <= 1'b1;
        if (i_rst || i_hsel || (wrise && push_ok) || (o_rd_valid && i_rd_ready)) quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
    end
    AST_PIN_CLEAR: assert property (
        !i_test_reset_n [*4] |-> !o_q_oe_n) else $error("oe high after test reset");
    AST_FIVE_EDGES: assert property (
        edge_ff == 3'h5 |-> ##[0:6] !o_q_oe_n) else $error("five edges left oe high");
    AST_HIZ_UNTIL: assert property (
        !o_q_oe_n |-> seen_ff) else $error("oe low without controller reset");
    AST_OE_KEEP: assert property (
        !o_q_oe_n |=> !o_q_oe_n) else $error("oe rose without reset");
    AST_NO_CAUSE: assert property (
        $rose(o_rd_valid) |-> quiet_ff < 4'hA) else $error("word appeared without write");
    AST_SYNC_PUSH: assert property (
        $rose(i_wr_clk) && push_ok && !i_async_write && i_master_reset_n && !o_rd_valid
        |-> ##[1:10] o_rd_valid) else $error("sync write lost");
    AST_ASYNC_PUSH: assert property (
        $rose(i_wr_clk) && push_ok && i_async_write && i_master_reset_n && !o_rd_valid
        |-> ##[1:10] o_rd_valid) else $error("strobe write lost");
    COV_FIVE: cover property (edge_ff == 3'h5 ##[1:6] $fell(o_q_oe_n));
    COV_POP: cover property (o_rd_valid && i_rd_ready);
    COV_OVF: cover property (o_wr_overflow);
endmodule : wport_top_assertions
bind wport_top wport_top_assertions wport_top_assertions_inst (.*);
`default_nettype wire

// ==== sim/wport_top_bench.sv ====
/* self-checking bench for wport_top over AHB-Lite and write pins.
   uses wport_writer as upstream and a stalling reader. */
`timescale 1ns/1ps
`default_nettype none
module wport_top_bench;
    import wport_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_rst, i_write_level_select, i_async_write, i_master_reset_n;
    logic        i_test_reset_n, i_test_clk, i_test_mode_sel, i_rd_ready, i_hsel, i_hwrite;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic [31:0] i_haddr, i_hwdata, v;
    wire logic   i_wr_clk, i_write_en_n, i_write_port_select_n, i_hready;
    wire logic   o_rd_valid, o_q_oe_n, o_wr_overflow, o_hreadyout, o_hresp;
    wire logic [31:0] i_wr_data, o_rd_data, o_q_out, o_hrdata;
    int          err_total = 0, n_checks = 0, cyc = 0, ovf_n = 0;
    assign i_hready = o_hreadyout;
    wport_top wport_top_inst (.*);
    wport_writer wport_writer_inst (.i_sys_clk, .o_wr_clk(i_wr_clk), .o_write_en_n(i_write_en_n),
        .o_write_port_select_n(i_write_port_select_n), .o_wr_data(i_wr_data));
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (o_wr_overflow === 1'b1) ovf_n++;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge i_sys_clk);
        i_haddr <= {20'h0, a};
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= w;
        i_hsel <= 1'b1;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        i_htrans <= 2'h0;
        i_hsel <= 1'b0;
        i_hwdata <= wd;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        v = o_hrdata;
    endtask : bus
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(nm, v, exp);
        chk("hresp", 32'(o_hresp), 32'h0);
    endtask : rd_chk
    task automatic pop(input logic [31:0] exp);
        int n = 0;
        while (o_rd_valid !== 1'b1 && n < 40) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk("rd_data", o_rd_data, exp);
        chk("q_out", o_q_out, exp);
        i_rd_ready <= 1'b1;
        @(posedge i_sys_clk);
        i_rd_ready <= 1'b0;
        @(posedge i_sys_clk);
    endtask : pop
    task automatic remode(input logic lvl, input logic asy);
        i_master_reset_n <= 1'b0;
        i_write_level_select <= lvl;
        i_async_write <= asy;
        repeat (4) @(posedge i_sys_clk);
        i_master_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
    endtask : remode
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        {i_rst, i_master_reset_n, i_test_reset_n} = 3'h5;
        {i_write_level_select, i_async_write, i_test_clk, i_test_mode_sel} = 4'h0;
        {i_rd_ready, i_hsel, i_hwrite, i_htrans, i_haddr, i_hwdata} = 69'h0;
        i_hsize = 3'h2;
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        remode(1'b0, 1'b0);
        chk("oe", 32'(o_q_oe_n), 32'h1);
        i_test_mode_sel <= 1'b1;
        for (int k = 1; k <= 5; k++) begin
            if (k == 5) chk("oe4", 32'(o_q_oe_n), 32'h1);
            repeat (3) @(posedge i_sys_clk);
            i_test_clk <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            i_test_clk <= 1'b0;
        end
        repeat (4) @(posedge i_sys_clk);
        i_test_mode_sel <= 1'b0;
        chk("oe5", 32'(o_q_oe_n), 32'h0);
        rd_chk("status", STATUS_OFS, 32'h3);
        rd_chk("ctrl", CTRL_OFS, 32'(CTRL_RESET));
        bus(CTRL_OFS, 1'b1, 32'h3);
        rd_chk("ctrl", CTRL_OFS, 32'h3);
        bus(CTRL_OFS, 1'b1, 32'h0);
        rd_chk("unmapped", 12'h010, 32'h0);
        wport_writer_inst.put(32'hA5A50001, 1'b0, 1'b0, 3);
        wport_writer_inst.put(32'hDEAD0002, 1'b1, 1'b0, 3);
        wport_writer_inst.put(32'h5A5A0003, 1'b0, 1'b0, 7);
        pop(32'hA5A50001);
        pop(32'h5A5A0003);
        for (int i = 0; i < 9; i++) bus(DATA_OFS, 1'b1, 32'h100 + i);
        rd_chk("full", STATUS_OFS, 32'h805);
        wport_writer_inst.put(32'hBAD00004, 1'b0, 1'b0, 3);
        repeat (8) @(posedge i_sys_clk);
        chk("overflow", 32'(ovf_n), 32'h1);
        for (int i = 0; i < 9; i++) pop(32'h100 + i);
        rd_chk("empty", STATUS_OFS, 32'h3);
        remode(1'b1, 1'b0);
        wport_writer_inst.put(32'h0BAD0005, 1'b0, 1'b1, 3);
        wport_writer_inst.put(32'h600D0006, 1'b0, 1'b0, 3);
        pop(32'h600D0006);
        rd_chk("level", STATUS_OFS, 32'h13);
        remode(1'b0, 1'b1);
        wport_writer_inst.put(32'h77770007, 1'b0, 1'b0, 3);
        pop(32'h77770007);
        rd_chk("async", STATUS_OFS, 32'hB);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        chk("oe_rst", 32'(o_q_oe_n), 32'h1);
        {i_master_reset_n, i_test_reset_n} <= 2'h0;
        repeat (4) @(posedge i_sys_clk);
        {i_master_reset_n, i_test_reset_n} <= 2'h3;
        repeat (4) @(posedge i_sys_clk);
        chk("oe_tied", 32'(o_q_oe_n), 32'h0);
        close_out();
    end
endmodule : wport_top_bench
`default_nettype wire

// ==== sim/wport_writer.sv ====
/* upstream writer model driving the write pins of wport_top.
   runs off the system clock; strobe phases of three or more cycles. */
`timescale 1ns/1ps
`default_nettype none
module wport_writer
    import wport_pkg::*;
(
    input  wire logic              i_sys_clk,
    output logic                   o_wr_clk,
    output logic                   o_write_en_n,
    output logic                   o_write_port_select_n,
    output logic [DATA_W-1:0]      o_wr_data
);
    initial begin
        o_wr_clk = 1'b0;
        o_write_en_n = 1'b1;
        o_write_port_select_n = 1'b1;
        o_wr_data = 32'h0;
    end
    task automatic put(input logic [DATA_W-1:0] d, input logic en_n, input logic sel_n,
                       input int hold);
        @(posedge i_sys_clk);
        o_wr_data <= d;
        o_write_en_n <= en_n;
        o_write_port_select_n <= sel_n;
        repeat (3) @(posedge i_sys_clk);
        o_wr_clk <= 1'b1;
        repeat (hold) @(posedge i_sys_clk);
        o_wr_clk <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        o_wr_data <= ~d;
        o_write_port_select_n <= 1'b1;
    endtask : put
endmodule : wport_writer
`default_nettype wire
